// ---- rtl/cntacc_pkg.sv ----
// Constants and types for the counter access window and link interrupt enable
// Summary of operation
// [R1] Upper register reads counter byte three
// [R2] Upper register bits 15:8 read zero
// [R3] Middle register reads bytes two and one
// [R4] Writes hold pending counter load value
// [R5] Holding and select registers feed transfers
// [R6] Type codes 1011..1000 select UTOPIA input counters
// [R7] Type codes 0111..0100 select transmit counters
// [R8] Type codes 0011..0000 select receive counters
// [R9] Software writes only listed type/index codes
// [R10] Index top bit selects IMA group
// [R11] Index 00000..01111 selects link 0..15
// [R12] Enabled link with status drives interrupt low
// [R13] Disabled link never affects interrupt pin
// [R14] Software starts transfer with command 01
// [R15] Direction 0 writes counter, 1 reads it
// [R16] Done bit reads one when transfer finished
// [R17] Unlatched per-link master status bit provided
// [R18] Holding keeps value until rewrite or read
// [R19] Enable changes reach pin immediately
package cntacc_pkg;
   // ======================================
   // Register indices and byte addresses
   localparam logic [11:0] CNTACC_IDX_UPPER = 12'h430;
   localparam logic [11:0] CNTACC_IDX_MIDDLE = 12'h431;
   localparam logic [11:0] CNTACC_IDX_SELECT = 12'h432;
   localparam logic [11:0] CNTACC_IDX_MENABLE = 12'h433;
   localparam logic [11:0] CNTACC_IDX_COMMAND = 12'h40f;
   localparam logic [11:0] CNTACC_IDX_MSTATUS = 12'h455;
   localparam logic [13:0] CNTACC_ADDR_UPPER = {CNTACC_IDX_UPPER, 2'b00};
   localparam logic [13:0] CNTACC_ADDR_MIDDLE = {CNTACC_IDX_MIDDLE, 2'b00};
   localparam logic [13:0] CNTACC_ADDR_SELECT = {CNTACC_IDX_SELECT, 2'b00};
   localparam logic [13:0] CNTACC_ADDR_MENABLE = {CNTACC_IDX_MENABLE, 2'b00};
   localparam logic [13:0] CNTACC_ADDR_COMMAND = {CNTACC_IDX_COMMAND, 2'b00};
   localparam logic [13:0] CNTACC_ADDR_MSTATUS = {CNTACC_IDX_MSTATUS, 2'b00};
   // ======================================
   // Field positions
   localparam int CNTACC_SEL_TYPE_LSB = 5;
   localparam int CNTACC_SEL_TYPE_MSB = 8;
   localparam int CNTACC_SEL_IDX_MSB = 4;
   localparam int CNTACC_CMD_DONE_BIT = 7;
   localparam int CNTACC_CMD_DIR_BIT = 2;
   localparam logic [1:0] CNTACC_CMD_XFER = 2'h1;
   localparam logic [15:0] CNTACC_SEL_MASK = 16'h01ff;
   localparam logic [15:0] CNTACC_RST_HALF = 16'h0000;
   localparam logic [7:0] CNTACC_RST_BYTE = 8'h00;
   // ======================================
   // Counter type codes
   typedef enum logic [3:0] {
      CNTACC_RX_BADICP = 4'b0000, CNTACC_RX_HEC = 4'b0001,
      CNTACC_RX_IDLE = 4'b0010, CNTACC_RX_ALL = 4'b0011,
      CNTACC_TX_ICP = 4'b0100, CNTACC_TX_STUFF = 4'b0101,
      CNTACC_TX_IDLE = 4'b0110, CNTACC_TX_ALL = 4'b0111,
      CNTACC_UI_HEC = 4'b1000, CNTACC_UI_UNASG = 4'b1001,
      CNTACC_UI_IDLE = 4'b1010, CNTACC_UI_ALL = 4'b1011
   } cntacc_ctype_type;
   typedef enum logic [1:0] {
      CNTACC_IDLE = 2'b00, CNTACC_REQ = 2'b01, CNTACC_LOAD = 2'b10
   } cntacc_state_type;
endpackage

// ---- rtl/cntacc_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cntacc_sync (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic din_i,
   output logic dout_o
);
   logic s1_q, s2_q, s3_q, out_q, out_d;
   // Accept a change once stages two and three agree
   always_comb begin
      out_d = out_q;
      if (s2_q == s3_q) begin
         out_d = s2_q;
      end
   end
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         s1_q <= din_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end
   assign dout_o = out_q;
endmodule

// ---- rtl/cntacc_top.sv ----
// Counter access window, transfer command and link interrupt enable
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module cntacc_top
   import cntacc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Counter store side
   output logic cnt_req_o,
   output logic cnt_dir_o,
   output logic [3:0] cnt_type_o,
   output logic [4:0] cnt_index_o,
   output logic [23:0] cnt_wdata_o,
   input wire logic cnt_ack_i,
   input wire logic [23:0] cnt_rdata_i,
   // Per-link interrupt requests from outside the clock domain
   input wire logic [15:0] link_irq_req_i,
   output logic irq_n_o
);
   // ======================================
   // Bus decode
   logic acc_w, acc_r;
   logic [13:0] byte_addr;
   logic hit;
   assign byte_addr = paddr_i[13:0];
   // Writes to unmapped or aliased addresses are dropped
   assign acc_w = psel_i & penable_i & pwrite_i & hit;
   assign acc_r = psel_i & penable_i & ~pwrite_i;
   assign pready_o = 1'b1;
   always_comb begin
      hit = 1'b0;
      if (paddr_i[15:14] == 2'b00) begin
         case (byte_addr)
            CNTACC_ADDR_UPPER, CNTACC_ADDR_MIDDLE, CNTACC_ADDR_SELECT,
            CNTACC_ADDR_MENABLE, CNTACC_ADDR_COMMAND, CNTACC_ADDR_MSTATUS: hit = 1'b1;
            default: hit = 1'b0;
         endcase
      end
   end
   // Unmapped addresses answer with an error
   assign pslverr_o = psel_i & penable_i & ~hit;

   // ======================================
   // Link status synchronisers
   logic [15:0] mstatus;
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_sync
         cntacc_sync u_sync (
            .mclk_i(mclk_i),
            .rstn_i(rstn_i),
            .din_i(link_irq_req_i[g]),
            .dout_o(mstatus[g])
         );
      end
   endgenerate

   // ======================================
   // Registers and transfer engine
   logic [7:0] upper_q, upper_d;
   logic [15:0] middle_q, middle_d;
   logic [8:0] select_q, select_d;
   logic [15:0] menable_q, menable_d;
   logic dir_q, dir_d;
   logic done_q, done_d;
   logic irq_n_q, irq_n_d;
   cntacc_state_type state_q, state_d;

   // Register writes and transfer sequencing
   always_comb begin
      upper_d = upper_q;
      middle_d = middle_q;
      select_d = select_q;
      menable_d = menable_q;
      dir_d = dir_q;
      done_d = done_q;
      state_d = state_q;
      if (acc_w) begin
         case (byte_addr)
            CNTACC_ADDR_UPPER: upper_d = pwdata_i[7:0]; // [R4] [R18]
            CNTACC_ADDR_MIDDLE: middle_d = pwdata_i[15:0]; // [R4] [R18]
            CNTACC_ADDR_SELECT: select_d = pwdata_i[8:0]; // [R9]
            CNTACC_ADDR_MENABLE: menable_d = pwdata_i[15:0];
            CNTACC_ADDR_COMMAND: begin
               // Command 01 starts a counter transfer
               if (pwdata_i[1:0] == CNTACC_CMD_XFER && state_q == CNTACC_IDLE) begin // [R14]
                  dir_d = pwdata_i[CNTACC_CMD_DIR_BIT]; // [R15]
                  done_d = 1'b0; // [R16]
                  state_d = CNTACC_REQ;
               end
            end
            default: ;
         endcase
      end
      case (state_q)
         CNTACC_IDLE: ;
         CNTACC_REQ: begin
            if (cnt_ack_i) begin
               state_d = dir_q ? CNTACC_LOAD : CNTACC_IDLE;
               done_d = ~dir_q; // [R16]
            end
         end
         CNTACC_LOAD: begin
            // Read transfer refreshes the holding registers
            upper_d = cnt_rdata_i[23:16]; // [R15] [R18]
            middle_d = cnt_rdata_i[15:0];
            done_d = 1'b1; // [R16]
            state_d = CNTACC_IDLE;
         end
         default: state_d = CNTACC_IDLE;
      endcase
      // Interrupt pin follows status and enable directly
      irq_n_d = ~|(mstatus & menable_d); // [R12] [R13] [R17] [R19]
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         upper_q <= CNTACC_RST_BYTE;
         middle_q <= CNTACC_RST_HALF;
         select_q <= 9'h000;
         menable_q <= CNTACC_RST_HALF;
         dir_q <= 1'b0;
         done_q <= 1'b1;
         irq_n_q <= 1'b1;
         state_q <= CNTACC_IDLE;
      end else begin
         upper_q <= upper_d;
         middle_q <= middle_d;
         select_q <= select_d;
         menable_q <= menable_d;
         dir_q <= dir_d;
         done_q <= done_d;
         irq_n_q <= irq_n_d;
         state_q <= state_d;
      end
   end

   // ======================================
   // Counter store request
   assign cnt_req_o = (state_q == CNTACC_REQ);
   assign cnt_dir_o = dir_q; // [R15]
   assign cnt_type_o = select_q[CNTACC_SEL_TYPE_MSB:CNTACC_SEL_TYPE_LSB]; // [R5] [R6] [R7] [R8]
   assign cnt_index_o = select_q[CNTACC_SEL_IDX_MSB:0]; // [R5] [R10] [R11]
   assign cnt_wdata_o = {upper_q, middle_q}; // [R5]
   assign irq_n_o = irq_n_q;

   // ======================================
   // Read data
   logic [31:0] rdata_q, rdata_d;
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (psel_i & ~penable_i & ~pwrite_i) begin
         case (byte_addr)
            CNTACC_ADDR_UPPER: rdata_d = {24'h000000, upper_q}; // [R1] [R2]
            CNTACC_ADDR_MIDDLE: rdata_d = {16'h0000, middle_q}; // [R3]
            CNTACC_ADDR_SELECT: rdata_d = {23'h000000, select_q};
            CNTACC_ADDR_MENABLE: rdata_d = {16'h0000, menable_q};
            CNTACC_ADDR_COMMAND: rdata_d = {24'h000000, done_q, 4'h0, dir_q, 2'b00}; // [R16]
            CNTACC_ADDR_MSTATUS: rdata_d = {16'h0000, mstatus}; // [R17]
            default: rdata_d = 32'h0000_0000;
         endcase
      end else if (acc_r) begin
         rdata_d = rdata_q;
      end
   end
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign prdata_o = rdata_q;
endmodule

// ---- tb/cntacc_chk_sva.sv ----
// Port checker for the counter access window
`timescale 1ns/1ps
module cntacc_chk
   import cntacc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic cnt_req_o,
   input wire logic cnt_ack_i,
   input wire logic [3:0] cnt_type_o,
   input wire logic [4:0] cnt_index_o,
   input wire logic [23:0] cnt_wdata_o,
   input wire logic [15:0] link_irq_req_i,
   input wire logic irq_n_o
);
   // ======================================
   // Access decode helpers
   wire logic acc = psel_i && penable_i;
   wire logic wr = acc && pwrite_i;
   wire logic a_up = paddr_i == {2'b00, CNTACC_ADDR_UPPER};
   wire logic a_mid = paddr_i == {2'b00, CNTACC_ADDR_MIDDLE};
   wire logic a_sel = paddr_i == {2'b00, CNTACC_ADDR_SELECT};
   wire logic a_cmd = paddr_i == {2'b00, CNTACC_ADDR_COMMAND};
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   a_upper_top_zero: assert property (acc && !pwrite_i && a_up |-> prdata_o[15:8] == 8'h00)
      else $error("upper byte register top bits not zero");
   a_upper_hold_wr: assert property (wr && a_up |=> cnt_wdata_o[23:16] == $past(pwdata_i[7:0]))
      else $error("upper holding byte not stored");
   a_middle_hold_wr: assert property (wr && a_mid |=> cnt_wdata_o[15:0] == $past(pwdata_i[15:0]))
      else $error("middle holding bytes not stored");
   a_type_follows_sel: assert property (wr && a_sel |=> cnt_type_o == $past(pwdata_i[8:5]))
      else $error("counter type does not follow select");
   a_index_follows_sel: assert property (wr && a_sel |=> cnt_index_o == $past(pwdata_i[4:0]))
      else $error("counter index does not follow select");
   a_holding_steady: assert property (!(wr && (a_up || a_mid)) && !cnt_req_o && !$past(cnt_req_o)
      |=> $stable(cnt_wdata_o))
      else $error("holding value changed without cause");
   a_req_until_ack: assert property (cnt_req_o && !cnt_ack_i |=> cnt_req_o)
      else $error("transfer request dropped before ack");
   a_cmd_starts_xfer: assert property (wr && a_cmd && pwdata_i[1:0] == CNTACC_CMD_XFER && !cnt_req_o
      |-> ##[1:2] cnt_req_o)
      else $error("transfer command did not start");
   a_irq_quiet: assert property ((link_irq_req_i == 16'h0000) [*6] |=> irq_n_o)
      else $error("interrupt low with no link request");
   c_xfer: cover property (cnt_req_o && cnt_ack_i);
   c_irq: cover property (!irq_n_o);
   c_sel: cover property (wr && a_sel);
endmodule
bind cntacc_top cntacc_chk u_chk (.*);

// ---- tb/tb_counter_access_irq_enable.sv ----
// Self-checking bench for the counter access window
`timescale 1ns/1ps
module tb_counter_access_irq_enable;
   import cntacc_pkg::*;
   logic mclk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, cnt_ack_i = 0;
   logic [15:0] paddr_i = 16'h0000, link_irq_req_i = 16'h0000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, r, u, m;
   logic [23:0] cnt_rdata_i = 24'h0, cnt_wdata_o;
   logic pready_o, pslverr_o, cnt_req_o, cnt_dir_o, irq_n_o;
   logic [3:0] cnt_type_o, b;
   logic [4:0] cnt_index_o;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   int n_mismatch = 0, num_checks = 0, seed = 82;
   cntacc_top uut (.*);
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   // ======================================
   // Compare, verdict and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
      input logic [63:0] x);
      @(posedge mclk_i);
      if (!w) exp_q.push_back(x);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= {2'b00, a};
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 64'h0);
   endtask
   task automatic rd(input logic [13:0] a, input logic [31:0] k, input logic [31:0] x);
      apb(1'b0, a, 32'h0, {k, x});
   endtask
   task automatic xfer(input logic d, input logic [23:0] v);
      #1;
      for (int i = 0; i < 20 && cnt_req_o !== 1'b1; i++) @(posedge mclk_i);
      chk({30'h0, cnt_req_o, cnt_dir_o}, {30'h0, 1'b1, d});
      rd(CNTACC_ADDR_COMMAND, 32'h80, 32'h00);
      cnt_ack_i <= 1'b1;
      cnt_rdata_i <= v;
      @(posedge mclk_i);
      cnt_ack_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
   endtask
   // Read monitor takes the oldest note per read
   always @(posedge mclk_i) begin
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
         e = exp_q.pop_front();
         chk(prdata_o & e[63:32], e[31:0]);
         chk({31'h0, pslverr_o}, {31'h0, paddr_i == 16'h1000});
      end
   end
   initial begin
      repeat (5000) @(posedge mclk_i);
      n_mismatch++;
      close_out();
   end
   // ======================================
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rd(CNTACC_ADDR_MIDDLE, 32'hffffffff, 32'h0);
      rd(CNTACC_ADDR_SELECT, 32'hffffffff, 32'h0);
      rd(CNTACC_ADDR_MENABLE, 32'hffffffff, 32'h0);
      rd(CNTACC_ADDR_COMMAND, 32'h80, 32'h80);
      for (int t = 0; t < 12; t++) begin
         r = $random(seed);
         r[8:0] = {t[3:0], (t > 7) ? r[4:0] % 5'd24 : {1'b0, r[3:0]}};
         wr(CNTACC_ADDR_SELECT, r);
         rd(CNTACC_ADDR_SELECT, 32'hffffffff, r & 32'h1ff);
         chk({23'h0, cnt_type_o, cnt_index_o}, {23'h0, r[8:0]});
      end
      u = $random(seed);
      m = $random(seed);
      wr(CNTACC_ADDR_UPPER, u);
      wr(CNTACC_ADDR_MIDDLE, m);
      rd(CNTACC_ADDR_MIDDLE, 32'hffffffff, {16'h0, m[15:0]});
      wr(CNTACC_ADDR_COMMAND, 32'h1);
      chk({8'h0, cnt_wdata_o}, {8'h0, u[7:0], m[15:0]});
      xfer(1'b0, 24'h5a5a5a);
      rd(CNTACC_ADDR_UPPER, 32'hffffffff, {24'h0, u[7:0]});
      r = $random(seed);
      wr(CNTACC_ADDR_COMMAND, 32'h5);
      xfer(1'b1, r[23:0]);
      rd(CNTACC_ADDR_UPPER, 32'hffffffff, {24'h0, r[23:16]});
      rd(CNTACC_ADDR_MIDDLE, 32'hffffffff, {16'h0, r[15:0]});
      rd(14'h1000, 32'hffffffff, 32'h0);
      for (int k = 0; k < 4; k++) begin
         r = $random(seed);
         b = r[3:0];
         link_irq_req_i <= 16'h1 << b;
         wr(CNTACC_ADDR_MENABLE, {16'h0, ~(16'h1 << b)});
         repeat (8) @(posedge mclk_i);
         chk({31'h0, irq_n_o}, 32'h1);
         rd(CNTACC_ADDR_MSTATUS, 32'hffff, {16'h0, 16'h1 << b});
         wr(CNTACC_ADDR_MENABLE, {16'h0, 16'h1 << b});
         @(posedge mclk_i);
         #1 chk({31'h0, irq_n_o}, 32'h0);
      end
      close_out();
   end
endmodule
